/* File: rtl/dual_pointer_consts.svh */
// offsets, field positions and reset values of the dual data pointer unit
`ifndef DUAL_POINTER_CONSTS_SVH
`define DUAL_POINTER_CONSTS_SVH
`define OFS_POINTER_CONTROL 12'h29c
`define OFS_POINTER_LOW     12'h208
`define OFS_POINTER_HIGH    12'h20c
`define OFS_POINTER_PAGE    12'h210
`define OFS_CORE_MOVE       12'h220
`define OFS_POINTER_STATUS  12'h224
`define IDX_POINTER_CONTROL 8'ha7
`define IDX_POINTER_LOW     8'h82
`define IDX_POINTER_HIGH    8'h83
`define IDX_POINTER_PAGE    8'h84
`define IDX_CORE_MOVE       8'h88
`define IDX_POINTER_STATUS  8'h89
`define BIT_POINTER_SELECT  0
`define BIT_AUTO_TOGGLE     6
`define MSB_SHADOW_MODE     5
`define LSB_SHADOW_MODE     4
`define MSB_MAIN_MODE       3
`define LSB_MAIN_MODE       2
`define CONTROL_WRITE_MASK  8'h7d
`define CONTROL_RESET       8'h00
`define POINTER_RESET       24'h000000
`define MOVE_KIND_LSB       0
`define MOVE_KIND_MSB       1
`endif

/* File: rtl/dual_pointer_pkg.sv */
// types of the dual data pointer unit
package dual_pointer_pkg;
   typedef enum logic [1:0] {
      MODE_NONE,
      MODE_INC,
      MODE_DEC,
      MODE_FLIP
   } ptr_mode_t;
   typedef enum logic [1:0] {
      MOVE_BY_POINTER,
      MOVE_BY_PC,
      MOVE_BY_REG,
      MOVE_OTHER
   } move_kind_t;
endpackage : dual_pointer_pkg

/* File: rtl/pointer_bank.sv */
// two 24-bit pointer registers with a registered read of the active one
`timescale 1ns/1ps
`include "dual_pointer_consts.svh"
module pointer_bank (
   input  wire logic        clk_sys,    // system clock
   input  wire logic        rstSync_n,  // synchronised reset, active low
   input  wire logic        wrEn,       // write one pointer
   input  wire logic        wrSel,      // 0 main, 1 shadow
   input  wire logic [23:0] wrData,     // new pointer value
   input  wire logic        rdSel,      // pointer to show
   output logic      [23:0] rdData,     // registered active pointer
   output logic      [23:0] mainPtr,    // main pointer now
   output logic      [23:0] shadowPtr   // shadow pointer now
);
   logic [23:0] ptr_q [2];

   genvar g;
   generate
      for (g = 0; g < 2; g++)
      begin : gPtr
         always_ff @(posedge clk_sys or negedge rstSync_n)
         begin
            if (!rstSync_n)
               ptr_q[g] <= `POINTER_RESET;
            else if (wrEn && (wrSel == 1'(g)))
               ptr_q[g] <= wrData;
         end
      end
   endgenerate

   always_ff @(posedge clk_sys or negedge rstSync_n)
   begin
      if (!rstSync_n)
         rdData <= `POINTER_RESET;
      else if (wrEn && (wrSel == rdSel))
         rdData <= wrData;
      else
         rdData <= ptr_q[rdSel];
   end

   assign mainPtr   = ptr_q[0];
   assign shadowPtr = ptr_q[1];
endmodule : pointer_bank

/* File: rtl/dual_pointer_unit.sv */
// dual 24-bit data pointer unit with control register, reached over apb
//
// Functional notes
// - select bit 0 low makes the main pointer active.
// - select bit high makes the shadow pointer active.
// - pointers are 24 bits; low, high, page registers show only the active one.
// - auto-toggle bit 6 set inverts select after each pointer-addressed move; a control write in the same cycle sets select instead.
// - auto-toggle clear leaves select alone; only register writes change it.
// - shadow mode bits 5:4: none, increment, decrement, flip bit 0.
// - main mode bits 3:2: none, increment, decrement, flip bit 0.
// - bit 1 unimplemented so incrementing control flips select only.
// - actions apply only to data/code moves addressed by the pointer.
// - moves by program counter or working register change nothing.
// - bit 7 reserved, reads zero, no function.
// - other pointer uses reach the active pointer.
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
`include "dual_pointer_consts.svh"
module dual_pointer_unit (
   input  wire logic        clk_sys,    // system clock, 250 MHz
   input  wire logic        nrst,       // asynchronous reset, active low
   input  wire logic        psel,       // apb select
   input  wire logic        penable,    // apb access phase
   input  wire logic        pwrite,     // apb direction
   input  wire logic [11:0] paddr,      // apb byte address
   input  wire logic [31:0] pwdata,     // apb write data
   output logic      [31:0] prdata,     // apb read data
   output logic             pready,     // apb ready
   output logic             pslverr,    // apb error
   input  wire logic        moveDone,   // core finished a move, one cycle
   input  wire logic [1:0]  moveKind,   // addressing kind of that move
   output logic      [23:0] activePtr,  // active pointer for the core
   output logic             selShadow   // select bit as seen by the core
);
   logic        rstMeta_q;
   logic        rst_n;
   logic [7:0]  control_q;
   logic        access;
   logic        wrAccess;
   logic        moveHit;
   logic        modeHit;
   logic        bankWr;
   logic        bankSel;
   logic [23:0] bankData;
   logic [23:0] mainPtr;
   logic [23:0] shadowPtr;
   logic [23:0] curPtr;
   logic [23:0] movedPtr;
   logic [23:0] wrPtr;
   logic [23:0] bankRd;
   logic        nextSel;
   logic        addrOk;
   dual_pointer_pkg::ptr_mode_t  curMode;

   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         rstMeta_q <= 1'b0;
         rst_n     <= 1'b0;
      end
      else
      begin
         rstMeta_q <= 1'b1;
         rst_n     <= rstMeta_q;
      end
   end

   // apb with one wait state: access phase answered on its second cycle
   assign access   = psel && penable && !pready;
   // writes land on the edge that samples pready high, the one the master commits on
   assign wrAccess = psel && penable && pready && pwrite;

   always_comb
   begin
      unique case (paddr)
         `OFS_POINTER_CONTROL, `OFS_POINTER_LOW, `OFS_POINTER_HIGH,
         `OFS_POINTER_PAGE, `OFS_CORE_MOVE, `OFS_POINTER_STATUS:
            addrOk = 1'b1;
         default:
            addrOk = 1'b0;
      endcase
   end

   assign curPtr  = control_q[`BIT_POINTER_SELECT] ? shadowPtr : mainPtr;
   assign curMode = control_q[`BIT_POINTER_SELECT]
                  ? dual_pointer_pkg::ptr_mode_t'(control_q[`MSB_SHADOW_MODE:`LSB_SHADOW_MODE])
                  : dual_pointer_pkg::ptr_mode_t'(control_q[`MSB_MAIN_MODE:`LSB_MAIN_MODE]);
   // only pointer-addressed moves act; pc or register moves are ignored
   assign moveHit = moveDone
                  && (dual_pointer_pkg::move_kind_t'(moveKind)
                      == dual_pointer_pkg::MOVE_BY_POINTER);

   always_comb
   begin
      unique case (curMode)
         dual_pointer_pkg::MODE_INC:  movedPtr = curPtr + 24'h000001;
         dual_pointer_pkg::MODE_DEC:  movedPtr = curPtr - 24'h000001;
         dual_pointer_pkg::MODE_FLIP: movedPtr = {curPtr[23:1], ~curPtr[0]};
         dual_pointer_pkg::MODE_NONE: movedPtr = curPtr;
      endcase
   end
   assign modeHit = moveHit && (curMode != dual_pointer_pkg::MODE_NONE);

   // byte writes go to the active pointer only
   always_comb
   begin
      wrPtr = curPtr;
      unique case (paddr)
         `OFS_POINTER_LOW:  wrPtr[7:0]   = pwdata[7:0];
         `OFS_POINTER_HIGH: wrPtr[15:8]  = pwdata[7:0];
         `OFS_POINTER_PAGE: wrPtr[23:16] = pwdata[7:0];
         default:           wrPtr        = curPtr;
      endcase
   end

   // a pointer byte write in the same cycle as a move wins over the move
   assign bankWr   = (wrAccess && (paddr == `OFS_POINTER_LOW || paddr == `OFS_POINTER_HIGH
                     || paddr == `OFS_POINTER_PAGE)) || modeHit;
   assign bankSel  = control_q[`BIT_POINTER_SELECT];
   assign bankData = (wrAccess && addrOk && paddr != `OFS_POINTER_CONTROL
                      && paddr != `OFS_CORE_MOVE && paddr != `OFS_POINTER_STATUS)
                   ? wrPtr : movedPtr;

   pointer_bank uBank (
      .clk_sys   (clk_sys),
      .rstSync_n (rst_n),
      .wrEn      (bankWr),
      .wrSel     (bankSel),
      .wrData    (bankData),
      .rdSel     (nextSel),
      .rdData    (bankRd),
      .mainPtr   (mainPtr),
      .shadowPtr (shadowPtr)
   );

   always_comb
   begin
      nextSel = control_q[`BIT_POINTER_SELECT];
      if (wrAccess && paddr == `OFS_POINTER_CONTROL)
         nextSel = pwdata[`BIT_POINTER_SELECT];
      else if (moveHit && control_q[`BIT_AUTO_TOGGLE])
         nextSel = ~control_q[`BIT_POINTER_SELECT];
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         control_q <= `CONTROL_RESET;
      else if (wrAccess && paddr == `OFS_POINTER_CONTROL)
         control_q <= pwdata[7:0] & `CONTROL_WRITE_MASK;
      else
         control_q[`BIT_POINTER_SELECT] <= nextSel;
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
      end
      else
      begin
         pready  <= access;
         pslverr <= access && !addrOk;
         prdata  <= 32'h00000000;
         if (access && !pwrite)
         begin
            unique case (paddr)
               `OFS_POINTER_CONTROL: prdata <= {24'h000000, control_q};
               `OFS_POINTER_LOW:     prdata <= {24'h000000, curPtr[7:0]};
               `OFS_POINTER_HIGH:    prdata <= {24'h000000, curPtr[15:8]};
               `OFS_POINTER_PAGE:    prdata <= {24'h000000, curPtr[23:16]};
               `OFS_POINTER_STATUS:  prdata <= {8'h00, curPtr};
               default:              prdata <= 32'h00000000;
            endcase
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         activePtr <= `POINTER_RESET;
         selShadow <= 1'b0;
      end
      else
      begin
         activePtr <= (bankWr && bankSel == nextSel) ? bankData
                      : (nextSel ? shadowPtr : mainPtr);
         selShadow <= nextSel;
      end
   end

   // assertions
   property p_main_active;
      @(posedge clk_sys) disable iff (!rst_n)
      !selShadow |-> activePtr == mainPtr;
   endproperty
   a_main_active: assert property (p_main_active)
      else $error("main pointer not active with select low");

   property p_shadow_active;
      @(posedge clk_sys) disable iff (!rst_n)
      selShadow |-> activePtr == shadowPtr;
   endproperty
   a_shadow_active: assert property (p_shadow_active)
      else $error("shadow pointer not active with select high");

   property p_toggle;
      @(posedge clk_sys) disable iff (!rst_n)
      moveHit && control_q[`BIT_AUTO_TOGGLE] && !wrAccess
      |=> control_q[`BIT_POINTER_SELECT] != $past(control_q[`BIT_POINTER_SELECT]);
   endproperty
   a_toggle: assert property (p_toggle)
      else $error("auto toggle did not swap pointers");

   property p_no_toggle;
      @(posedge clk_sys) disable iff (!rst_n)
      !wrAccess |=> $stable(control_q[`BIT_POINTER_SELECT])
                    || $past(moveHit && control_q[`BIT_AUTO_TOGGLE]);
   endproperty
   a_no_toggle: assert property (p_no_toggle)
      else $error("select changed without cause");

   property p_reserved;
      @(posedge clk_sys) disable iff (!rst_n)
      control_q[7] == 1'b0 && control_q[1] == 1'b0;
   endproperty
   a_reserved: assert property (p_reserved)
      else $error("unimplemented control bit set");

   property p_ignored_move;
      @(posedge clk_sys) disable iff (!rst_n)
      moveDone && !moveHit && !wrAccess
      |=> $stable(mainPtr) && $stable(shadowPtr) && $stable(control_q);
   endproperty
   a_ignored_move: assert property (p_ignored_move)
      else $error("non-pointer move changed state");

   property p_increment;
      @(posedge clk_sys) disable iff (!rst_n)
      modeHit && !wrAccess && curMode == dual_pointer_pkg::MODE_INC
      |=> ($past(control_q[0]) ? shadowPtr : mainPtr) == $past(curPtr) + 24'h000001;
   endproperty
   a_increment: assert property (p_increment)
      else $error("post increment wrong");

   property p_other_kept;
      @(posedge clk_sys) disable iff (!rst_n)
      modeHit && !wrAccess
      |=> ($past(control_q[0]) ? mainPtr : shadowPtr)
          == $past(control_q[0] ? mainPtr : shadowPtr);
   endproperty
   a_other_kept: assert property (p_other_kept)
      else $error("inactive pointer changed on move");

   property p_decrement;
      @(posedge clk_sys) disable iff (!rst_n)
      modeHit && !wrAccess && curMode == dual_pointer_pkg::MODE_DEC
      |=> ($past(control_q[0]) ? shadowPtr : mainPtr) == $past(curPtr) - 24'h000001;
   endproperty
   a_decrement: assert property (p_decrement)
      else $error("post decrement wrong");

   property p_flip;
      @(posedge clk_sys) disable iff (!rst_n)
      modeHit && !wrAccess && curMode == dual_pointer_pkg::MODE_FLIP
      |=> ($past(control_q[0]) ? shadowPtr : mainPtr) == ($past(curPtr) ^ 24'h000001);
   endproperty
   a_flip: assert property (p_flip)
      else $error("pointer bit 0 not inverted");

   property p_no_action;
      @(posedge clk_sys) disable iff (!rst_n)
      moveHit && !wrAccess && curMode == dual_pointer_pkg::MODE_NONE
      |=> $stable(mainPtr) && $stable(shadowPtr);
   endproperty
   a_no_action: assert property (p_no_action)
      else $error("pointer changed in plain mode");

   // the core-facing copy must agree with the bank's own registered read
   property p_bank_read;
      @(posedge clk_sys) disable iff (!rst_n)
      activePtr == bankRd;
   endproperty
   a_bank_read: assert property (p_bank_read)
      else $error("active pointer differs from bank read");

   property p_status_read;
      @(posedge clk_sys) disable iff (!rst_n)
      access && !pwrite && paddr == `OFS_POINTER_STATUS
      |=> prdata == {8'h00, $past(curPtr)};
   endproperty
   a_status_read: assert property (p_status_read)
      else $error("status read is not the active pointer");

   sequence s_toggle_move;
      moveHit && control_q[`BIT_AUTO_TOGGLE] && !wrAccess;
   endsequence

   sequence s_core_sees_swap;
      ##1 selShadow != $past(control_q[`BIT_POINTER_SELECT]);
   endsequence

   property p_toggle_seen;
      @(posedge clk_sys) disable iff (!rst_n)
      s_toggle_move |-> s_core_sees_swap;
   endproperty
   a_toggle_seen: assert property (p_toggle_seen)
      else $error("core select did not follow auto toggle");
endmodule : dual_pointer_unit

/* File: testbench/core_model.sv */
// core-side model that issues data pointer move pulses
`timescale 1ns/1ps
module core_model (
   input  wire logic       clk_sys,   // system clock
   output logic            moveDone,  // one-cycle move pulse
   output logic      [1:0] moveKind   // addressing kind of the move
);
   initial
   begin
      moveDone = 1'b0;
      moveKind = 2'h3;
   end
   // kind is inverted outside the pulse so a stale value cannot pass for a real one
   task automatic issue(input logic [1:0] kind);
      @(posedge clk_sys);
      moveDone <= 1'b1;
      moveKind <= kind;
      @(posedge clk_sys);
      moveDone <= 1'b0;
      moveKind <= ~kind;
   endtask : issue
endmodule : core_model

/* File: testbench/dual_data_pointer_unit_tb_top.sv */
// self-checking bench of the dual data pointer unit against an integer model
`timescale 1ns/1ps
`include "dual_pointer_consts.svh"
module dual_data_pointer_unit_tb_top;
   logic        clk_sys, nrst, psel, penable, pwrite, pready, pslverr, moveDone, selShadow, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [1:0]  moveKind;
   logic [23:0] activePtr;
   int          n_errors, num_checks, ctrlM, v, i, j;
   int          ptrM [2];

   dual_pointer_unit dut (.clk_sys(clk_sys), .nrst(nrst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .moveDone(moveDone), .moveKind(moveKind), .activePtr(activePtr),
      .selShadow(selShadow));
   core_model core (.clk_sys(clk_sys), .moveDone(moveDone), .moveKind(moveKind));

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : tally_and_finish

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask : check

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_sys);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk_sys);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50)
      begin
         n_errors++;
         tally_and_finish();
      end
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   function automatic int expRead(input logic [11:0] a);
      int s;
      s = ctrlM & 1;
      case (a)
         `OFS_POINTER_CONTROL: return ctrlM;
         `OFS_POINTER_LOW:     return ptrM[s] & 'hff;
         `OFS_POINTER_HIGH:    return (ptrM[s] >> 8) & 'hff;
         `OFS_POINTER_PAGE:    return (ptrM[s] >> 16) & 'hff;
         `OFS_POINTER_STATUS:  return ptrM[s];
         default:              return 0;
      endcase
   endfunction : expRead

   task automatic rreg(input logic [11:0] a);
      apb(1'b0, a, 32'h0);
      check(rd, expRead(a));
      check({31'h0, err}, 32'h0);
   endtask : rreg

   task automatic wreg(input logic [11:0] a, input logic [31:0] d);
      int s;
      apb(1'b1, a, d);
      check({31'h0, err}, 32'h0);
      s = ctrlM & 1;
      case (a)
         `OFS_POINTER_CONTROL: ctrlM = d & 32'h7d;
         `OFS_POINTER_LOW:     ptrM[s] = (ptrM[s] & 'hffff00) | (d & 'hff);
         `OFS_POINTER_HIGH:    ptrM[s] = (ptrM[s] & 'hff00ff) | ((d & 'hff) << 8);
         `OFS_POINTER_PAGE:    ptrM[s] = (ptrM[s] & 'h00ffff) | ((d & 'hff) << 16);
         default:              ;
      endcase
   endtask : wreg

   task automatic loadPtr(input int p);
      wreg(`OFS_POINTER_LOW, p & 'hff);
      wreg(`OFS_POINTER_HIGH, (p >> 8) & 'hff);
      wreg(`OFS_POINTER_PAGE, (p >> 16) & 'hff);
   endtask : loadPtr

   task automatic move(input logic [1:0] k);
      int s, m;
      core.issue(k);
      s = ctrlM & 1;
      m = s ? (ctrlM >> 4) & 3 : (ctrlM >> 2) & 3;
      if (k == 2'h0)
      begin
         case (m)
            1:       ptrM[s] = (ptrM[s] + 1) & 'hffffff;
            2:       ptrM[s] = (ptrM[s] - 1) & 'hffffff;
            3:       ptrM[s] = ptrM[s] ^ 1;
            default: ;
         endcase
         if (ctrlM & 'h40)
            ctrlM = ctrlM ^ 1;
      end
      // outputs are registered, so give them two full cycles to settle
      @(posedge clk_sys);
      @(posedge clk_sys);
      check({31'h0, selShadow}, ctrlM & 1);
      check({8'h0, activePtr}, ptrM[ctrlM & 1]);
   endtask : move

   initial
   begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end

   initial
   begin
      #200000;
      n_errors++;
      tally_and_finish();
   end

   initial
   begin
      nrst = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      n_errors = 0;
      num_checks = 0;
      ctrlM = 0;
      ptrM = '{0, 0};
      void'($urandom(32'ha2e7bb05));
      repeat (20) @(posedge clk_sys);
      nrst <= 1'b1;
      repeat (3) @(posedge clk_sys);
      rreg(`OFS_POINTER_CONTROL);
      rreg(`OFS_POINTER_STATUS);
      rreg(`OFS_CORE_MOVE);
      $display("test reset values done");
      wreg(`OFS_POINTER_CONTROL, 32'hffffffff);
      rreg(`OFS_POINTER_CONTROL);
      apb(1'b1, 12'h000, 32'h0);
      check({31'h0, err}, 32'h1);
      apb(1'b0, 12'h004, 32'h0);
      check({err, rd[30:0]}, 32'h80000000);
      rreg(`OFS_POINTER_CONTROL);
      $display("test control mask and unmapped done");
      for (i = 0; i < 2; i++)
      begin
         wreg(`OFS_POINTER_CONTROL, i);
         loadPtr($urandom);
         rreg(`OFS_POINTER_LOW);
         rreg(`OFS_POINTER_HIGH);
         rreg(`OFS_POINTER_PAGE);
         rreg(`OFS_POINTER_STATUS);
      end
      $display("test pointer select done");
      for (i = 0; i < 32; i++)
      begin
         wreg(`OFS_POINTER_CONTROL, (i << 2) | ($urandom & 'h83));
         v = (i % 3 == 0) ? 'hffffff : (i % 3 == 1) ? 0 : $urandom;
         loadPtr(v);
         for (j = 0; j < 4; j++)
            move(($urandom % 2) ? 2'h0 : 2'($urandom));
         wreg(`OFS_POINTER_CONTROL, ctrlM ^ 1);
         rreg(`OFS_POINTER_STATUS);
      end
      $display("test move actions done");
      for (i = 0; i < 2; i++)
      begin
         rreg(`OFS_POINTER_CONTROL);
         v = ctrlM ^ 1;
         wreg(`OFS_POINTER_CONTROL, rd + 32'h1);
         rreg(`OFS_POINTER_CONTROL);
         check(rd, v);
      end
      $display("test control increment done");
      loadPtr($urandom);
      nrst <= 1'b0;
      repeat (2) @(posedge clk_sys);
      check({6'h0, pready, pslverr, activePtr}, 32'h0);
      check({31'h0, selShadow}, 32'h0);
      check(prdata, 32'h0);
      nrst <= 1'b1;
      ctrlM = 0;
      ptrM = '{0, 0};
      repeat (3) @(posedge clk_sys);
      rreg(`OFS_POINTER_CONTROL);
      rreg(`OFS_POINTER_STATUS);
      $display("test mid-run reset done");
      tally_and_finish();
   end
endmodule : dual_data_pointer_unit_tb_top
